// >>> adc_seq_consts.svh
/*
  Constants of the conversion sequencer: control bit positions, reset
  values and timing counts. Assumes a 50 MHz system clock.
*/
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

`define CLK_PERIOD_NS   20
`define DECIDE_DELAY_NS 40
`define DECIDE_DLY_CYC  (`DECIDE_DELAY_NS / `CLK_PERIOD_NS)
`define STROBE_EDGE_NS  12
`define STROBE_EDGE_CYC ((`STROBE_EDGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CR_DUAL 6
`define CR_PD   8
`define CR_POL  9

`define CTRL_RESET 10'h000
`define RES_RESET  10'h000
`define PINS_IDLE  5'h1C
`define AGE_MAX    4'hF

// first falling edge plus four complete cycles
`define ACQ_FALL_EDGES 3'h5
// conversion-clock ticks counted from the hold edge
`define MSB_TICK   4'h1
`define BIT2_TICK  4'h3
`define BITN_FIRST 4'h4
`define BITN_LAST  4'hB
`define BITN_BASE  4'hB
`define DONE_TICK  4'hC
`define MSB_IDX    4'h9
`define BIT2_IDX   4'h8

`endif

// >>> adc_seq_pkg.sv
/*
  Types of the conversion sequencer: pin group and sequencer states.
  Assumes nothing of its surroundings.
*/
package adc_seq_pkg;
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic conversion_clock;
    logic comp;
  } pins_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_ABORT, ST_PDOWN} state_t;
endpackage

// >>> adc_conversion_sequencer_port.sv
/*
  Sequencer and parallel host port of a 10-bit successive-approximation
  converter. Assumes the host strobes, the conversion clock and the
  comparator arrive asynchronously; conversion clock half period at least
  four clk cycles; data_port_in held until four clk edges after write rise.
*/
// What this block does
// - write strobe rising edge starts a cycle by tracking the selected input
// - input held shortly after first rising edge after four clock cycles
// - falling edge too close to the write strobe is not counted
// - two settling cycles after hold, then most significant bit decided
// - second bit two cycles later, then one bit per rising edge
// - single mode: flag changes, result one loaded, approximation cleared
// - dual mode: second conversion follows, then flag changes, result two loaded
// - thirteen clock cycles per conversion after about five acquisition cycles
// - powerdown write ends any conversion and switches analog off
// - powerdown write during conversion forces flag high on its leading edge
// - strobes work in powerdown; results kept and readable
// - leaving powerdown starts conversions that overwrite results
// - zero powerdown bit exits; other control bits kept or reloaded
// - flag driven high during powerdown
// - chip select high leaves data port undriven
// - chip select low, read high: write loads control and starts
// - single mode reads always return result one
// - dual mode reads alternate result one and result two
// - read during conversion stops it; data unreliable
// - write during conversion aborts, flag high, new sequence follows
// - polarity bit: zero low while converting, one low when finished
// - ten-bit write-only control register cleared at reset
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module adc_conversion_sequencer_port #(
  parameter int DECIDE_DLY = `DECIDE_DLY_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire adc_seq_pkg::pins_t pins_in,
  input  wire logic [9:0]        data_port_in,
  output logic      [9:0]        data_port_out,
  output logic                   data_port_oe_n,
  output logic                   busy_int_n,
  output logic                   track_hold,
  output logic                   analog_on,
  output logic      [9:0]        dac_code,
  output logic      [9:0]        control_word
);
  import adc_seq_pkg::*;

  if (DECIDE_DLY < 1) begin : g_chk
    $error("DECIDE_DLY must be at least 1");
  end

  // decision slot for the tick after count c: {valid, bit index}
  function automatic logic [4:0] pend(input logic [3:0] c);
    logic [3:0] idx;
    logic       v;
    idx = (c < 4'h2) ? `MSB_IDX : (c < `BITN_FIRST) ? `BIT2_IDX : 4'(`BITN_BASE - c);
    v   = (c == `MSB_TICK) || (c == `BIT2_TICK) || (c >= `BITN_FIRST && c <= `BITN_LAST);
    return {v, idx};
  endfunction

  // pin synchronisers and filtered levels
  pins_t            s1_q, s2_q, s3_q, lvl_q, prev_q, lvl_d;
  logic [9:0]       d1_q, d2_q, d3_q;
  logic [DECIDE_DLY-1:0] rise_dly_q, rise_dly_d;

  always_comb begin
    lvl_d      = pins_t'((s3_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q)));
    rise_dly_d = (rise_dly_q << 1) | DECIDE_DLY'(lvl_q.conversion_clock &
                 ~prev_q.conversion_clock);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q       <= `PINS_IDLE;
      s2_q       <= `PINS_IDLE;
      s3_q       <= `PINS_IDLE;
      lvl_q      <= `PINS_IDLE;
      prev_q     <= `PINS_IDLE;
      d1_q       <= `RES_RESET;
      d2_q       <= `RES_RESET;
      d3_q       <= `RES_RESET;
      rise_dly_q <= '0;
    end else begin
      s1_q       <= pins_in;
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      lvl_q      <= lvl_d;
      prev_q     <= lvl_q;
      d1_q       <= data_port_in;
      d2_q       <= d1_q;
      d3_q       <= d2_q;
      rise_dly_q <= rise_dly_d;
    end
  end

  // strobe and clock events
  logic sel, wr_rise, wr_fall, rd_fall, rd_rise, cclk_fall, tick, running, quiet, end_ev;
  logic [4:0] pq;

  always_comb begin
    sel       = ~lvl_q.cs_n;
    wr_rise   = sel & lvl_q.rd_n & ~prev_q.wr_n & lvl_q.wr_n;
    wr_fall   = sel & prev_q.wr_n & ~lvl_q.wr_n;
    rd_fall   = sel & ~lvl_q.rd_n & (prev_q.cs_n | prev_q.rd_n);
    rd_rise   = ~prev_q.cs_n & ~prev_q.rd_n & (lvl_q.cs_n | lvl_q.rd_n);
    cclk_fall = prev_q.conversion_clock & ~lvl_q.conversion_clock;
    tick      = rise_dly_q[DECIDE_DLY-1];
  end

  // sequencer state
  state_t     state_q, state_d;
  logic [9:0] ctrl_q, ctrl_d, sar_q, sar_d, r1_q, r1_d, r2_q, r2_d;
  logic [3:0] cnt_q, cnt_d, age_q, age_d;
  logic [2:0] fall_q, fall_d;
  logic       second_q, second_d, done_q, done_d, rdsel_q, rdsel_d, hold_q, hold_d;
  logic       flag_d, oe_n_d, dual;
  logic [9:0] dout_d, dac_d;
  logic [4:0] pn;

  always_comb begin
    state_d  = state_q;
    ctrl_d   = ctrl_q;
    sar_d    = sar_q;
    r1_d     = r1_q;
    r2_d     = r2_q;
    cnt_d    = cnt_q;
    age_d    = age_q;
    fall_d   = fall_q;
    second_d = second_q;
    done_d   = done_q;
    rdsel_d  = rdsel_q;
    hold_d   = hold_q;
    running  = (state_q == ST_ACQ) || (state_q == ST_CONV);
    quiet    = ~wr_rise & ~wr_fall & ~rd_fall;
    end_ev   = (state_q == ST_CONV) & tick & (cnt_q == `DONE_TICK);
    dual     = ctrl_q[`CR_DUAL];
    pq       = pend(cnt_q);
    if (wr_rise) begin
      ctrl_d = d3_q;
      done_d = 1'b0;
      hold_d = 1'b0;
      if (d3_q[`CR_PD]) begin
        state_d = ST_PDOWN;
      end else begin
        state_d  = ST_ACQ;
        fall_d   = 3'h0;
        age_d    = 4'h0;
        second_d = 1'b0;
        sar_d    = `RES_RESET;
      end
    end else if (wr_fall && running) begin
      state_d = ST_ABORT;
      hold_d  = 1'b0;
    end else if (rd_fall && running) begin
      state_d = ST_IDLE;
      hold_d  = 1'b0;
    end else begin
      case (state_q)
        ST_ACQ: begin
          if (age_q != `AGE_MAX) begin
            age_d = age_q + 4'h1;
          end
          if (cclk_fall && age_q >= 4'(`STROBE_EDGE_CYC) && fall_q != `ACQ_FALL_EDGES) begin
            fall_d = fall_q + 3'h1;
          end
          if (tick && fall_q == `ACQ_FALL_EDGES) begin
            hold_d  = 1'b1;
            state_d = ST_CONV;
            cnt_d   = 4'h0;
          end
        end
        ST_CONV: begin
          if (tick) begin
            cnt_d = cnt_q + 4'h1;
            if (pq[4]) begin
              sar_d[pq[3:0]] = lvl_q.comp;
            end
            if (end_ev) begin
              if (second_q) begin
                r2_d = sar_q;
              end else begin
                r1_d = sar_q;
              end
              sar_d = `RES_RESET;
              cnt_d = 4'h0;
              if (dual && !second_q) begin
                second_d = 1'b1;
              end else begin
                state_d = ST_IDLE;
                done_d  = 1'b1;
                hold_d  = 1'b0;
              end
            end
          end
        end
        ST_ABORT, ST_PDOWN, ST_IDLE: begin
          state_d = state_q;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    if (end_ev && quiet && state_d == ST_IDLE) begin
      rdsel_d = 1'b0;
    end else if (rd_rise && dual) begin
      rdsel_d = ~rdsel_q;
    end else if (!dual) begin
      rdsel_d = 1'b0;
    end
    // flag: high in powerdown or abort, else by polarity
    if (state_d == ST_PDOWN || state_d == ST_ABORT) begin
      flag_d = 1'b1;
    end else if (state_d == ST_ACQ || state_d == ST_CONV) begin
      flag_d = ctrl_d[`CR_POL];
    end else begin
      flag_d = ctrl_d[`CR_POL] ? ~done_d : 1'b1;
    end
    oe_n_d = ~(sel & ~lvl_q.rd_n & lvl_q.wr_n);
    dout_d = rdsel_q ? r2_q : r1_q;
    pn     = pend(cnt_d);
    dac_d  = (state_d == ST_CONV && pn != 5'h0) ?
             (sar_d | (10'h001 << pn[3:0])) : sar_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q        <= ST_IDLE;
      ctrl_q         <= `CTRL_RESET;
      sar_q          <= `RES_RESET;
      r1_q           <= `RES_RESET;
      r2_q           <= `RES_RESET;
      cnt_q          <= 4'h0;
      age_q          <= 4'h0;
      fall_q         <= 3'h0;
      second_q       <= 1'b0;
      done_q         <= 1'b0;
      rdsel_q        <= 1'b0;
      hold_q         <= 1'b0;
      busy_int_n     <= 1'b1;
      data_port_oe_n <= 1'b1;
      data_port_out  <= `RES_RESET;
      dac_code       <= `RES_RESET;
      analog_on      <= 1'b1;
    end else begin
      state_q        <= state_d;
      ctrl_q         <= ctrl_d;
      sar_q          <= sar_d;
      r1_q           <= r1_d;
      r2_q           <= r2_d;
      cnt_q          <= cnt_d;
      age_q          <= age_d;
      fall_q         <= fall_d;
      second_q       <= second_d;
      done_q         <= done_d;
      rdsel_q        <= rdsel_d;
      hold_q         <= hold_d;
      busy_int_n     <= flag_d;
      data_port_oe_n <= oe_n_d;
      data_port_out  <= dout_d;
      dac_code       <= dac_d;
      analog_on      <= (state_d != ST_PDOWN);
    end
  end

  assign track_hold   = hold_q;
  assign control_word = ctrl_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_pd_flag_high: assert property (state_q == ST_PDOWN |-> busy_int_n)
    else $error("flag not high in powerdown");
  a_cs_high_hiz: assert property (lvl_q.cs_n |=> data_port_oe_n)
    else $error("data port driven with chip select high");
  a_write_loads: assert property (wr_rise |=> control_word == $past(d3_q))
    else $error("control word not loaded by write");
  a_write_starts: assert property (wr_rise && !d3_q[`CR_PD] |=> state_q == ST_ACQ ##1
    !track_hold)
    else $error("write did not start acquisition");
  a_pd_enter: assert property (wr_rise && d3_q[`CR_PD] |=> state_q == ST_PDOWN ##1
    !analog_on && busy_int_n)
    else $error("powerdown not entered");
  a_abort_flag: assert property (wr_fall && running |=> busy_int_n && !track_hold)
    else $error("write abort did not raise flag");
  a_read_stops: assert property (rd_fall && running && !wr_fall |=> state_q == ST_IDLE)
    else $error("read did not stop conversion");
  a_single_load: assert property (end_ev && quiet && !second_q |=>
    r1_q == $past(sar_q) && sar_q == `RES_RESET)
    else $error("result one not loaded");
  a_dual_second: assert property (end_ev && quiet && dual && !second_q |=>
    second_q && state_q == ST_CONV && busy_int_n == $past(busy_int_n))
    else $error("second conversion not started");
  a_read_alt: assert property (rd_rise && dual && !(end_ev && quiet) |=>
    rdsel_q != $past(rdsel_q))
    else $error("read did not alternate");
  a_hold_after_acq: assert property ($rose(track_hold) |-> $past(fall_q) == `ACQ_FALL_EDGES)
    else $error("hold before acquisition complete");

  c_conv_done: cover property (end_ev && quiet && state_d == ST_IDLE);
  c_dual_run: cover property (end_ev && quiet && second_q);
  c_pdown: cover property (state_q == ST_PDOWN ##1 state_q == ST_ACQ);
  c_abort: cover property (wr_fall && running);

endmodule // adc_conversion_sequencer_port

// >>> sar_front_model.sv
/*
  front-end model of the converter: free conversion clock and comparator.
  assumes dac_code carries the pending trial code and target is held
  steady by the bench while a conversion runs.
*/
`timescale 1ns/1ps
module sar_front_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [9:0] dac_code,
  input  wire logic [9:0] target,
  output logic            conversion_clock,
  output logic            comp
);
  logic [2:0] div_q;

  // half period of five clk cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 3'h0;
      conversion_clock <= 1'b0;
    end else if (div_q == 3'h4) begin
      div_q <= 3'h0;
      conversion_clock <= ~conversion_clock;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // keep trial bit while trial code does not exceed the held input
  assign comp = (dac_code <= target);
endmodule // sar_front_model

// >>> adc_conversion_sequencer_port_tb.sv
/*
  bench of the conversion sequencer: host write and read tasks, checks.
  assumes the front-end model and the design files are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 10'(e), 10'(g))
module adc_conversion_sequencer_port_tb;
  import adc_seq_pkg::*;
  logic       clk        = 1'b0;
  logic       rst        = 1'b1;
  logic       cs_n       = 1'b1;
  logic       rd_n       = 1'b1;
  logic       wr_n       = 1'b1;
  logic [9:0] din        = 10'h000;
  logic [9:0] target     = 10'h000;
  logic [9:0] rdat;
  logic       oe_rd;
  logic       busy_wr_n;
  logic       cclk;
  logic       comp;
  logic       oe_n;
  logic       busy_n;
  logic       th;
  logic       aon;
  logic [9:0] dout;
  logic [9:0] dac;
  logic [9:0] cw;
  int         fails      = 0;
  int         num_checks = 0;
  int         cycles     = 0;
  int         t_wr       = 0;
  pins_t      pins;
  logic [9:0] exp3 [3]   = '{10'h155, 10'h3C3, 10'h155};

  assign pins = pins_t'({cs_n, rd_n, wr_n, cclk, comp});
  always #10 clk = ~clk;

  adc_conversion_sequencer_port adc_conversion_sequencer_port_inst (
    .clk(clk), .rst(rst), .pins_in(pins), .data_port_in(din), .data_port_out(dout),
    .data_port_oe_n(oe_n), .busy_int_n(busy_n), .track_hold(th), .analog_on(aon),
    .dac_code(dac), .control_word(cw));
  sar_front_model sar_front_model_inst (
    .clk(clk), .rst(rst), .dac_code(dac), .target(target),
    .conversion_clock(cclk), .comp(comp));

  task automatic check(input string n, input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic host_wr(input logic [9:0] v, input logic rd);
    cs_n = 1'b0;
    rd_n = rd;
    din = v;
    wr_n = 1'b0;
    tick(8);
    busy_wr_n = busy_n;
    wr_n = 1'b1;
    t_wr = cycles;
    tick(8);
    cs_n = 1'b1;
    rd_n = 1'b1;
    tick(2);
  endtask

  task automatic host_rd(input logic cs);
    cs_n = cs;
    rd_n = 1'b0;
    tick(8);
    rdat = dout;
    oe_rd = oe_n;
    cs_n = 1'b1;
    rd_n = 1'b1;
    tick(8);
  endtask

  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 1000 && busy_n !== lvl; i++) tick(1);
    `CHK("busy_wait", lvl, busy_n);
  endtask

  task automatic wait_dac(input logic nz);
    for (int i = 0; i < 500 && ((dac !== 10'h000) !== nz); i++) tick(1);
    `CHK("dac_wait", nz, dac !== 10'h000);
  endtask

  task automatic start_mid();
    host_wr(10'h005, 1'b1);
    tick(60);
  endtask

  task automatic dual_run(input logic [9:0] a, input logic [9:0] b);
    target = a;
    host_wr(10'h240, 1'b1);
    `CHK("flag_run", 1, busy_n);
    wait_dac(1'b1);
    // thirteen conversion clocks after hold: second conversion has begun
    tick(130);
    `CHK("flag_mid", 1, busy_n);
    `CHK("dac_second", 10'h200, dac);
    target = b;
    wait_busy(1'b0);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    tick(6);
    rst = 1'b0;
    tick(6);
    `CHK("ctrl_rst", 10'h000, cw);
    host_rd(1'b1);
    `CHK("hiz_cs", 1, oe_rd);
    target = 10'h2A5;
    host_wr(10'h005, 1'b1);
    `CHK("ctrl_load", 10'h005, cw);
    `CHK("flag_conv", 0, busy_n);
    wait_busy(1'b1);
    `CHK("conv_time", 1, (cycles - t_wr >= 180) && (cycles - t_wr <= 210));
    `CHK("sar_clear", 10'h000, dac);
    repeat (2) begin
      host_rd(1'b0);
      `CHK("rd_single", 10'h2A5, rdat);
      `CHK("rd_drive", 0, oe_rd);
    end
    host_wr(10'h3C0, 1'b0);
    `CHK("ctrl_keep", 10'h005, cw);
    host_wr(10'h105, 1'b1);
    `CHK("pd_analog", 0, aon);
    `CHK("pd_flag", 1, busy_n);
    host_rd(1'b0);
    `CHK("pd_keep", 10'h2A5, rdat);
    target = 10'h0F0;
    host_wr(10'h005, 1'b1);
    `CHK("pd_exit", 1, aon);
    `CHK("pd_restart", 0, busy_n);
    wait_busy(1'b1);
    host_rd(1'b0);
    `CHK("pd_result", 10'h0F0, rdat);
    target = 10'h2A5;
    start_mid();
    host_wr(10'h105, 1'b1);
    `CHK("pd_abort", 1, busy_wr_n);
    `CHK("pd_hold", 0, th);
    host_wr(10'h005, 1'b1);
    wait_busy(1'b1);
    start_mid();
    host_rd(1'b0);
    `CHK("rd_abort", 1, busy_n);
    `CHK("rd_abort_th", 0, th);
    start_mid();
    target = 10'h1E1;
    host_wr(10'h005, 1'b1);
    `CHK("wr_abort", 1, busy_wr_n);
    wait_busy(1'b1);
    host_rd(1'b0);
    `CHK("wr_restart", 10'h1E1, rdat);
    dual_run(10'h155, 10'h3C3);
    for (int i = 0; i < 3; i++) begin
      host_rd(1'b0);
      `CHK("rd_dual", exp3[i], rdat);
    end
    dual_run(10'h0F0, 10'h3C3);
    host_rd(1'b0);
    `CHK("rd_restart", 10'h0F0, rdat);
    tally_and_finish();
  end
endmodule // adc_conversion_sequencer_port_tb
